//--- verilog/apt_pkg.sv
package apt_pkg;

  localparam int          ENC_BITS_DEF      = 17;
  localparam int          MT_BITS           = 16;

  localparam logic [15:0] IDX_MODE_SEL      = 16'h0008;
  localparam logic [15:0] IDX_ENC_RESET     = 16'h0011;
  localparam logic [15:0] IDX_GEAR_NUM      = 16'h0019;
  localparam logic [15:0] IDX_GEAR_DEN      = 16'h001A;
  localparam logic [15:0] IDX_LIM_LO        = 16'h001B;
  localparam logic [15:0] IDX_LIM_HI        = 16'h001D;
  localparam logic [15:0] IDX_ROT_REF_LO    = 16'h0029;
  localparam logic [15:0] IDX_ROT_ENC_LO    = 16'h002B;
  localparam logic [15:0] IDX_ROT_ENC_HI    = 16'h002D;
  localparam logic [15:0] IDX_STATUS        = 16'h0040;
  localparam logic [15:0] IDX_OP_MODE       = 16'h6060;
  localparam logic [15:0] IDX_FB_ENC        = 16'h6063;
  localparam logic [15:0] IDX_FB_REF        = 16'h6064;
  localparam logic [15:0] IDX_TARGET        = 16'h607A;
  localparam logic [15:0] IDX_HOME_OFS      = 16'h607C;
  localparam logic [15:0] IDX_ST_FUNC       = 16'h60E6;

  localparam logic [15:0] RST_GEAR          = 16'h0001;
  localparam logic [15:0] RST_ENC_RESET     = 16'h0000;
  localparam logic [31:0] RST_WORD          = 32'h0000_0000;
  localparam logic [7:0]  RST_OP_MODE       = 8'h00;

  localparam logic [15:0] ENC_RESET_MT      = 16'h0004;
  localparam logic [15:0] ENC_RESET_MAX     = 16'h001F;
  localparam logic [7:0]  OP_MODE_HOMING    = 8'h06;
  localparam logic [11:0] BATT_WARN_MV      = 12'hBB8;
  // retention key marking a stored word as written; value is arbitrary
  localparam logic [31:0] NV_KEY            = 32'h5A3C_96E1;
  localparam logic        NV_ADDR_MODE      = 1'b0;
  localparam logic        NV_ADDR_FRAME     = 1'b1;

  typedef enum logic [2:0] {
    MODE_INCREMENTAL, MODE_LINEAR, MODE_LINEAR_INF,
    MODE_SINGLE_TURN, MODE_ROTATION, MODE_MECH_SINGLE
  } apt_mode_type;
  localparam logic [2:0]  MODE_MAX          = 3'h5;

  typedef enum logic [1:0] {ST_LOAD_MODE, ST_LOAD_FRAME, ST_LOAD_DONE, ST_RUN} apt_state_type;

  function automatic logic [63:0] apt_sext32(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction : apt_sext32

endpackage : apt_pkg

//--- verilog/apt_nv_store.sv
// retained store: the array has no reset so its contents survive a drive reset
module apt_nv_store
  import apt_pkg::*;
#(
  parameter int WIDTH = 96,
  parameter int AW    = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [2**AW];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : apt_nv_store

//--- verilog/apt_gear_div.sv
// restoring divider: (num << SHIFT) / den, one quotient bit per clock
module apt_gear_div
  import apt_pkg::*;
#(
  parameter int NW    = 16,
  parameter int SHIFT = ENC_BITS_DEF
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_start,
  input  wire logic [NW-1:0]      i_num,
  input  wire logic [NW-1:0]      i_den,
  output logic      [NW+SHIFT-1:0] o_quot,
  output logic                    o_busy
);

  localparam int DW = NW + SHIFT;

  logic [NW:0]   rem;
  logic [NW-1:0] den;
  logic [6:0]    cnt;
  wire  [NW:0]   rem_sh  = {rem[NW-1:0], o_quot[DW-1]};
  wire  [NW:0]   rem_sub = rem_sh - {1'b0, den};
  wire           take    = ~rem_sub[NW];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rem    <= '0;
      den    <= '0;
      cnt    <= '0;
      o_quot <= '0;
      o_busy <= 1'b0;
    end else if (i_start) begin
      rem    <= '0;
      den    <= i_den;
      cnt    <= 7'(DW);
      o_quot <= {i_num, {SHIFT{1'b0}}};
      o_busy <= 1'b1;
    end else if (o_busy) begin
      rem    <= take ? rem_sub : rem_sh;
      o_quot <= {o_quot[DW-2:0], take};
      cnt    <= cnt - 7'h01;
      o_busy <= (cnt != 7'h01);
    end
  end

endmodule : apt_gear_div

//--- verilog/apt_tracker.sv
// What this block does
// RULE_01: the rotation upper limit is the 64-bit limit pair, or the gear-ratio result when both halves are zero.
// RULE_02: single-turn mode neither counts revolutions nor needs the encoder battery.
// RULE_03: target positions are taken over the full signed 32-bit range with no modulus applied.
// RULE_04: at power-up single-turn feedback starts from the encoder single-turn position, 0 to 2^17-1.
// RULE_05: homing with selector 3 saves encoder position and home offset, restored at next power-up.
// RULE_06: after a successful homing the reference feedback equals the home offset.
// RULE_07: first battery attach raises the battery fault, cleared by the encoder data reset.
// RULE_08: the battery warning follows a level below 3.0 V and clears itself on a good battery.
// RULE_09: the operator swaps the battery only while powered and idle, resuming when the warning clears.
// RULE_10: an unpowered battery swap raises the fault; writing 4 to the data reset clears it.
// RULE_11: a multi-turn reset voids the saved frame and demands a new homing.
// RULE_12: selector codes 0 to 5 are the six absolute modes and take effect only after power-up.
// RULE_13: at-stop parameters are refused while the motor runs.
module apt_tracker
  import apt_pkg::*;
#(
  parameter int ENC_BITS = ENC_BITS_DEF
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire logic                i_par_wr,
  input  wire logic                i_par_rd,
  input  wire logic [15:0]         i_par_index,
  input  wire logic [31:0]         i_par_wdata,
  input  wire logic [ENC_BITS-1:0] i_enc_single_turn,
  input  wire logic [MT_BITS-1:0]  i_enc_multi_turn,
  input  wire logic [11:0]         i_batt_mv,
  input  wire logic                i_batt_first_attach,
  input  wire logic                i_batt_mt_lost,
  input  wire logic                i_motor_running,
  input  wire logic                i_homing_done,
  output logic      [31:0]         o_par_rdata,
  output logic                     o_par_ack,
  output logic                     o_par_err,
  output logic      [31:0]         o_target_pos,
  output logic                     o_enc_mt_reset,
  output logic                     o_enc_battery_fault,
  output logic                     o_enc_battery_warning,
  output logic                     o_homing_required,
  output logic                     o_mt_count_enable
);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  apt_state_type state;
  apt_mode_type  act_mode;
  logic [2:0]    mode_sel;
  logic [15:0]   gear_num, gear_den, enc_reset_cmd;
  logic [31:0]   lim_lo, lim_hi, home_ofs, st_func;
  logic [7:0]    op_mode;
  logic [63:0]   pos_enc, offset, rot_enc;
  logic [ENC_BITS-1:0] prev_st;
  logic          frame_valid;

  // pins from the encoder side: two flops each, three on attach and lost for edge detection; multi-bit counts assume slow change
  logic [ENC_BITS-1:0] enc_st_m, enc_st;
  logic [MT_BITS-1:0]  enc_mt_m, enc_mt;
  logic [11:0]         batt_m, batt;
  logic                first_m, first_s, first_d, lost_m, lost_s, lost_d;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      {enc_st_m, enc_st, enc_mt_m, enc_mt} <= '0;
      {batt_m, batt}                         <= '0;
      {first_m, first_s, first_d}            <= '0;
      {lost_m, lost_s, lost_d}               <= '0;
    end else begin
      {enc_st_m, enc_st} <= {i_enc_single_turn, enc_st_m};
      {enc_mt_m, enc_mt} <= {i_enc_multi_turn, enc_mt_m};
      {batt_m, batt}     <= {i_batt_mv, batt_m};
      {first_m, first_s, first_d} <= {i_batt_first_attach, first_m, first_s};
      {lost_m, lost_s, lost_d}    <= {i_batt_mt_lost, lost_m, lost_s};
    end
  end

  // retained store for the selector and the homing frame
  logic         nv_we;
  logic         nv_waddr;
  logic [95:0]  nv_wdata, nv_rdata;
  wire          nv_raddr  = (state == ST_LOAD_MODE) ? NV_ADDR_MODE : NV_ADDR_FRAME;
  wire          nv_key_ok = (nv_rdata[95:64] == NV_KEY);

  apt_nv_store #(.WIDTH(96), .AW(1)) u_nv (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_we      (nv_we),
    .i_waddr   (nv_waddr),
    .i_wdata   (nv_wdata),
    .i_raddr   (nv_raddr),
    .o_rdata   (nv_rdata)
  );

  // limit: explicit pair first, else one load turn in encoder pulses from the gear ratio
  logic                       div_start, div_busy;
  logic [16+ENC_BITS-1:0]     div_quot;
  wire  [63:0] lim_pair      = {lim_hi, lim_lo};
  wire         lim_pair_zero = (lim_pair == 64'h0);
  wire  [63:0] limit_eff     = lim_pair_zero ? 64'(div_quot) : lim_pair; // [RULE_01]

  apt_gear_div #(.NW(16), .SHIFT(ENC_BITS)) u_div (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_start   (div_start),
    .i_num     (gear_num),
    .i_den     (gear_den),
    .o_quot    (div_quot),
    .o_busy    (div_busy)
  );

  // parameter access decode
  wire idx_at_stop = (i_par_index == IDX_ENC_RESET) || (i_par_index == IDX_GEAR_NUM) ||
                     (i_par_index == IDX_GEAR_DEN) || (i_par_index == IDX_LIM_LO) ||
                     (i_par_index == IDX_LIM_HI) || (i_par_index == IDX_MODE_SEL);
  wire idx_rw      = idx_at_stop || (i_par_index == IDX_OP_MODE) || (i_par_index == IDX_TARGET) ||
                     (i_par_index == IDX_HOME_OFS) || (i_par_index == IDX_ST_FUNC);
  wire idx_ro      = (i_par_index == IDX_ROT_REF_LO) || (i_par_index == IDX_ROT_ENC_LO) ||
                     (i_par_index == IDX_ROT_ENC_HI) || (i_par_index == IDX_FB_ENC) ||
                     (i_par_index == IDX_FB_REF) || (i_par_index == IDX_STATUS);
  wire val_ok      = ((i_par_index != IDX_GEAR_NUM && i_par_index != IDX_GEAR_DEN) ||
                      (i_par_wdata[15:0] != 16'h0000 && i_par_wdata[31:16] == 16'h0000)) &&
                     (i_par_index != IDX_ENC_RESET || i_par_wdata <= 32'(ENC_RESET_MAX)) &&
                     (i_par_index != IDX_MODE_SEL || i_par_wdata <= 32'(MODE_MAX)); // [RULE_12]
  wire homing_ev   = i_homing_done && (op_mode == OP_MODE_HOMING) && (state == ST_RUN);
  wire stop_block  = idx_at_stop && i_motor_running; // [RULE_13]
  // the mode word shares the store port with the homing frame, so that write loses the clash
  wire nv_clash    = (i_par_index == IDX_MODE_SEL) && homing_ev;
  wire wr_ok       = i_par_wr && idx_rw && val_ok && !stop_block && !nv_clash;
  wire wr_bad      = i_par_wr && !wr_ok;
  wire rd_ok       = i_par_rd && !i_par_wr && (idx_rw || idx_ro);
  wire mt_reset_wr = wr_ok && (i_par_index == IDX_ENC_RESET) && (i_par_wdata[15:0] == ENC_RESET_MT);

  // position tracking
  wire               track_mode = (act_mode == MODE_INCREMENTAL) || (act_mode == MODE_SINGLE_TURN);
  wire [ENC_BITS-1:0] st_diff   = enc_st - prev_st;
  wire [63:0] st_delta  = {{(64-ENC_BITS){st_diff[ENC_BITS-1]}}, st_diff};
  wire [63:0] st_zx     = {{(64-ENC_BITS){1'b0}}, enc_st};
  wire [63:0] abs_enc   = {{(64-MT_BITS-ENC_BITS){1'b0}}, enc_mt, enc_st};
  wire [63:0] run_pos   = track_mode ? pos_enc + st_delta : abs_enc; // [RULE_02]
  wire [63:0] boot_pos  = track_mode ? st_zx : abs_enc;              // [RULE_04]
  wire [63:0] next_pos_enc = (state == ST_LOAD_DONE) ? boot_pos :
                             (state == ST_RUN) ? run_pos : pos_enc;
  wire        frame_ok  = nv_key_ok && nv_rdata[63] && (act_mode == MODE_SINGLE_TURN);
  wire [63:0] boot_ofs  = frame_ok ? apt_sext32(nv_rdata[62:31]) - {{(64-ENC_BITS){1'b0}}, nv_rdata[ENC_BITS-1:0]}
                                   : 64'h0; // [RULE_05]
  wire [63:0] next_offset = (state == ST_LOAD_DONE) ? boot_ofs :
                            homing_ev ? apt_sext32(home_ofs) - run_pos : offset; // [RULE_06]
  wire [63:0] pos_ref   = pos_enc + offset;
  wire [63:0] rot_sum   = rot_enc + st_delta;
  wire [63:0] next_rot  = (state == ST_LOAD_DONE) ? st_zx :
                          (limit_eff == 64'h0) ? rot_sum :
                          rot_sum[63] ? rot_sum + limit_eff :
                          (rot_sum >= limit_eff) ? rot_sum - limit_eff : rot_sum;
  wire        batt_req  = (state == ST_RUN) && (act_mode != MODE_SINGLE_TURN); // [RULE_02]
  wire        fault_set = batt_req && ((first_s && !first_d) || (lost_s && !lost_d)); // [RULE_07] [RULE_10]

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state       <= ST_LOAD_MODE;
      act_mode    <= MODE_INCREMENTAL;
      mode_sel    <= 3'h0;
      frame_valid <= 1'b0;
    end else begin
      case (state)
        ST_LOAD_MODE:  state <= ST_LOAD_FRAME;
        ST_LOAD_FRAME: begin
          state    <= ST_LOAD_DONE;
          // a never-written store reads unknown; the else branch keeps that a blank, incremental start
          if (nv_key_ok) begin
            act_mode <= apt_mode_type'(nv_rdata[2:0]); // [RULE_12]
            mode_sel <= nv_rdata[2:0];
          end else begin
            act_mode <= MODE_INCREMENTAL;
            mode_sel <= 3'h0;
          end
        end
        ST_LOAD_DONE:  begin
          state       <= ST_RUN;
          frame_valid <= frame_ok;
        end
        ST_RUN:        state <= ST_RUN;
        default:       state <= ST_LOAD_MODE;
      endcase
      if (wr_ok && i_par_index == IDX_MODE_SEL) begin
        mode_sel <= i_par_wdata[2:0];
      end
      if (homing_ev && act_mode == MODE_SINGLE_TURN) begin
        frame_valid <= 1'b1;
      end else if (mt_reset_wr) begin
        frame_valid <= 1'b0; // [RULE_11]
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gear_num      <= RST_GEAR;
      gear_den      <= RST_GEAR;
      enc_reset_cmd <= RST_ENC_RESET;
      lim_lo        <= RST_WORD;
      lim_hi        <= RST_WORD;
      home_ofs      <= RST_WORD;
      st_func       <= RST_WORD;
      o_target_pos  <= RST_WORD;
      op_mode       <= RST_OP_MODE;
    end else if (wr_ok) begin
      case (i_par_index)
        IDX_GEAR_NUM:  gear_num      <= i_par_wdata[15:0];
        IDX_GEAR_DEN:  gear_den      <= i_par_wdata[15:0];
        IDX_ENC_RESET: enc_reset_cmd <= i_par_wdata[15:0];
        IDX_LIM_LO:    lim_lo        <= i_par_wdata;
        IDX_LIM_HI:    lim_hi        <= i_par_wdata;
        IDX_HOME_OFS:  home_ofs      <= i_par_wdata;
        IDX_ST_FUNC:   st_func       <= i_par_wdata;
        IDX_TARGET:    o_target_pos  <= i_par_wdata; // [RULE_03]
        IDX_OP_MODE:   op_mode       <= i_par_wdata[7:0];
        default:       op_mode       <= op_mode;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_enc   <= '0;
      offset    <= '0;
      rot_enc   <= '0;
      prev_st   <= '0;
      div_start <= 1'b0;
      nv_we     <= 1'b0;
      nv_waddr  <= NV_ADDR_MODE;
      nv_wdata  <= '0;
    end else begin
      pos_enc   <= next_pos_enc;
      offset    <= next_offset;
      rot_enc   <= next_rot;
      prev_st   <= enc_st;
      div_start <= (state == ST_LOAD_DONE) ||
                   (wr_ok && (i_par_index == IDX_GEAR_NUM || i_par_index == IDX_GEAR_DEN)); // [RULE_01]
      nv_we     <= homing_ev && act_mode == MODE_SINGLE_TURN || mt_reset_wr ||
                   (wr_ok && i_par_index == IDX_MODE_SEL);
      if (homing_ev && act_mode == MODE_SINGLE_TURN) begin
        nv_waddr <= NV_ADDR_FRAME;
        nv_wdata <= {NV_KEY, 1'b1, home_ofs, {(31-ENC_BITS){1'b0}}, enc_st}; // [RULE_05]
      end else if (mt_reset_wr) begin
        nv_waddr <= NV_ADDR_FRAME;
        nv_wdata <= '0; // [RULE_11]
      end else begin
        nv_waddr <= NV_ADDR_MODE;
        nv_wdata <= {NV_KEY, 61'h0, i_par_wdata[2:0]};
      end
    end
  end

  // status: fault and homing demand are sticky; a set in the clearing cycle wins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_enc_battery_fault   <= 1'b0;
      o_enc_battery_warning <= 1'b0;
      o_homing_required     <= 1'b0;
      o_enc_mt_reset        <= 1'b0;
      o_mt_count_enable     <= 1'b0;
    end else begin
      o_enc_battery_fault   <= fault_set || (o_enc_battery_fault && !mt_reset_wr); // [RULE_07] [RULE_10]
      o_enc_battery_warning <= batt_req && (batt < BATT_WARN_MV); // [RULE_08]
      o_homing_required     <= mt_reset_wr || (o_homing_required && !homing_ev); // [RULE_11]
      o_enc_mt_reset        <= mt_reset_wr; // [RULE_10]
      o_mt_count_enable     <= (state == ST_RUN) && !track_mode; // [RULE_02]
    end
  end

  logic [31:0] rd_word;
  always_comb begin
    case (i_par_index)
      IDX_MODE_SEL:   rd_word = {29'h0, mode_sel};
      IDX_ENC_RESET:  rd_word = {16'h0, enc_reset_cmd};
      IDX_GEAR_NUM:   rd_word = {16'h0, gear_num};
      IDX_GEAR_DEN:   rd_word = {16'h0, gear_den};
      IDX_LIM_LO:     rd_word = lim_lo;
      IDX_LIM_HI:     rd_word = lim_hi;
      IDX_ROT_REF_LO: rd_word = rot_enc[31:0] + offset[31:0];
      IDX_ROT_ENC_LO: rd_word = rot_enc[31:0];
      IDX_ROT_ENC_HI: rd_word = rot_enc[63:32];
      IDX_FB_ENC:     rd_word = pos_enc[31:0];
      IDX_FB_REF:     rd_word = pos_ref[31:0];
      IDX_STATUS:     rd_word = {24'h0, act_mode, div_busy, o_homing_required,
                                 o_enc_battery_warning, o_enc_battery_fault, frame_valid};
      IDX_OP_MODE:    rd_word = {24'h0, op_mode};
      IDX_TARGET:     rd_word = o_target_pos;
      IDX_HOME_OFS:   rd_word = home_ofs;
      IDX_ST_FUNC:    rd_word = st_func;
      default:        rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_par_rdata <= '0;
      o_par_ack   <= 1'b0;
      o_par_err   <= 1'b0;
    end else begin
      o_par_rdata <= rd_ok ? rd_word : 32'h0;
      o_par_ack   <= i_par_wr || i_par_rd;
      o_par_err   <= wr_bad || (i_par_rd && !i_par_wr && !rd_ok); // [RULE_13]
    end
  end

  sequence s_homing;
    homing_ev && act_mode == MODE_SINGLE_TURN;
  endsequence
  sequence s_frame_write;
    nv_we && nv_waddr == NV_ADDR_FRAME && nv_wdata[95:64] == NV_KEY;
  endsequence

  property p_gear_limit;
    $fell(div_busy) && lim_pair_zero |-> limit_eff == (({48'h0, gear_num} << ENC_BITS) / {48'h0, gear_den});
  endproperty
  a_gear_limit: assert property (p_gear_limit) else $error("gear-derived limit wrong"); // [RULE_01]
  property p_no_count;
    state == ST_RUN && act_mode == MODE_SINGLE_TURN |=> !o_mt_count_enable && !$rose(o_enc_battery_fault);
  endproperty
  a_no_count: assert property (p_no_count) else $error("single-turn mode counts turns"); // [RULE_02]
  property p_target_raw;
    wr_ok && i_par_index == IDX_TARGET |=> o_target_pos == $past(i_par_wdata);
  endproperty
  a_target_raw: assert property (p_target_raw) else $error("target altered"); // [RULE_03]
  property p_boot_single;
    state == ST_LOAD_DONE && track_mode |=> pos_enc == {{(64-ENC_BITS){1'b0}}, $past(enc_st)};
  endproperty
  a_boot_single: assert property (p_boot_single) else $error("power-up feedback not single-turn"); // [RULE_04]
  property p_homing_frame;
    s_homing |=> s_frame_write ##1 frame_valid;
  endproperty
  a_homing_frame: assert property (p_homing_frame) else $error("homing frame not saved"); // [RULE_05]
  property p_home_ref;
    homing_ev |=> pos_ref[31:0] == $past(home_ofs);
  endproperty
  a_home_ref: assert property (p_home_ref) else $error("feedback not home offset"); // [RULE_06]
  property p_fault_set;
    batt_req && first_s && !first_d |=> o_enc_battery_fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("battery fault missed"); // [RULE_07]
  property p_warn;
    batt_req && batt < BATT_WARN_MV |=> o_enc_battery_warning ##1 (o_enc_battery_warning || $past(batt) >= BATT_WARN_MV || !$past(batt_req));
  endproperty
  a_warn: assert property (p_warn) else $error("battery warning wrong"); // [RULE_08]
  property p_reset_clear;
    mt_reset_wr && !fault_set |=> !o_enc_battery_fault && o_enc_mt_reset ##1 !o_enc_mt_reset;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("data reset did not clear"); // [RULE_10]
  property p_home_req;
    mt_reset_wr |=> o_homing_required && !frame_valid;
  endproperty
  a_home_req: assert property (p_home_req) else $error("frame not voided"); // [RULE_11]
  property p_mode_range;
    i_par_wr && i_par_index == IDX_MODE_SEL && i_par_wdata > 32'(MODE_MAX) |=> o_par_err && $stable(mode_sel);
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("bad selector accepted"); // [RULE_12]
  property p_at_stop;
    i_par_wr && i_motor_running && i_par_index == IDX_GEAR_NUM |=> o_par_err && $stable(gear_num);
  endproperty
  a_at_stop: assert property (p_at_stop) else $error("at-stop write taken while running"); // [RULE_13]

endmodule : apt_tracker

//--- test/apt_enc_model.sv
// encoder side: pins only move on the drive clock, like the encoder's serial refresh
module apt_enc_model
  import apt_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic [16:0]        i_st,
  input  wire logic [11:0]        i_mv,
  input  wire logic               i_attach,
  input  wire logic               i_lost,
  output logic      [16:0]        o_st = '0,
  output logic      [MT_BITS-1:0] o_mt = '0,
  output logic      [11:0]        o_mv = 12'hC00,
  output logic                    o_attach = 1'b0,
  output logic                    o_lost = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge i_ref_clk) begin
    o_st     <= i_st;
    o_mt     <= i_lost ? 16'h7F3A : 16'h0002; // unpowered swap scrambles the turn count
    o_mv     <= i_mv;                         // level only changes while powered
    o_attach <= i_attach;
    o_lost   <= i_lost;
  end
endmodule : apt_enc_model

//--- test/test_absolute_position_tracker.sv
module test_absolute_position_tracker
  import apt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk = 0, i_rst = 1, wr = 0, rd = 0, run = 0, hd = 0, att = 0, lost = 0, err, pulse;
  logic [15:0] idx = '0;
  logic [31:0] wd = '0, rdat, v, o_par_rdata, o_target_pos;
  logic [16:0] st = '0, st_p;
  logic [11:0] mv = 12'hC00, mv_p;
  logic [15:0] mt_p;
  logic att_p, lost_p, o_par_ack, o_par_err, o_mt_rst, o_flt, o_warn, o_hreq, o_mten;
  int fails = 0, num_checks = 0, cyc = 0, seed = 32'hf8cb;
  always #50 i_ref_clk = ~i_ref_clk;
  apt_enc_model i_apt_enc_model (.i_ref_clk(i_ref_clk), .i_st(st), .i_mv(mv), .i_attach(att), .i_lost(lost),
    .o_st(st_p), .o_mt(mt_p), .o_mv(mv_p), .o_attach(att_p), .o_lost(lost_p));
  apt_tracker i_apt_tracker (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_par_wr(wr), .i_par_rd(rd),
    .i_par_index(idx), .i_par_wdata(wd), .i_enc_single_turn(st_p), .i_enc_multi_turn(mt_p),
    .i_batt_mv(mv_p), .i_batt_first_attach(att_p), .i_batt_mt_lost(lost_p), .i_motor_running(run),
    .i_homing_done(hd), .o_par_rdata(o_par_rdata), .o_par_ack(o_par_ack), .o_par_err(o_par_err),
    .o_target_pos(o_target_pos), .o_enc_mt_reset(o_mt_rst), .o_enc_battery_fault(o_flt),
    .o_enc_battery_warning(o_warn), .o_homing_required(o_hreq), .o_mt_count_enable(o_mten));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] warn_exp(input logic [11:0] m);
    return {31'h0, m < BATT_WARN_MV};
  endfunction : warn_exp
  task automatic par(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge i_ref_clk);
    #10 {wr, rd, idx, wd} = {w, ~w, i, d};
    @(posedge i_ref_clk);
    // ack, error, read data and the reset pulse stand only until the next edge
    #10 {wr, rd} = 2'b00;
    {err, rdat, pulse} = {o_par_err, o_par_rdata, o_mt_rst};
    check({31'h0, o_par_ack}, 32'h1);
  endtask : par
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #10;
  endtask : wt
  task automatic boot(input int n);
    wt(0);
    i_rst = 1;
    wt(n);
    i_rst = 0;
    wt(6);
  endtask : boot
  task automatic home(input logic [31:0] ofs);
    par(1, IDX_OP_MODE, 32'h6);
    par(1, IDX_HOME_OFS, ofs);
    wt(1);
    hd = 1;
    wt(1);
    hd = 0;
    wt(3);
  endtask : home
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    v = $random(seed);
    boot(12);
    par(0, IDX_GEAR_NUM, 0); check(rdat, 32'h1);
    par(0, IDX_GEAR_DEN, 0); check(rdat, 32'h1);
    par(0, IDX_LIM_HI, 0); check(rdat, 32'h0);
    par(1, IDX_GEAR_NUM, 32'h0); check({31'h0, err}, 32'h1);
    par(1, IDX_GEAR_DEN, 32'h1_0000); check({31'h0, err}, 32'h1);
    v = $random(seed);
    v = {16'h0, v[15:0] | 16'h0001};
    par(1, IDX_GEAR_NUM, v); par(0, IDX_GEAR_NUM, 0); check(rdat, v);
    run = 1;
    par(1, IDX_GEAR_DEN, 32'h5); check({31'h0, err}, 32'h1);
    par(1, IDX_ENC_RESET, 32'h4); check({31'h0, err}, 32'h1);
    run = 0;
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 32'h8000_0000 : $random(seed);
      par(1, IDX_TARGET, v); check(o_target_pos, v);
    end
    for (int k = 0; k < 4; k++) begin
      mv = (k == 0) ? 12'hBB7 : (k == 1) ? 12'hBB8 : $random(seed);
      wt(5); check({31'h0, o_warn}, warn_exp(mv));
    end
    mv = 12'hC00;
    att = 1; wt(5); check({31'h0, o_flt}, 32'h1);
    att = 0;
    par(1, IDX_ENC_RESET, 32'h4); check({o_flt, o_hreq, pulse}, 3'b011);
    lost = 1; wt(5); lost = 0;
    par(1, IDX_ENC_RESET, 32'h2); check({31'h0, o_flt}, 32'h1);
    par(1, IDX_ENC_RESET, 32'h4); check({31'h0, o_flt}, 32'h0);
    v = $random(seed);
    home(v); par(0, IDX_FB_REF, 0); check(rdat, v);
    check({31'h0, o_hreq}, 32'h0);
    par(1, IDX_MODE_SEL, 32'h6); check({31'h0, err}, 32'h1);
    par(1, IDX_MODE_SEL, 32'h3); par(0, IDX_STATUS, 0); check(rdat[7:5], 3'h0);
    st = $random(seed);
    boot(3);
    par(0, IDX_FB_REF, 0); check(rdat, {15'h0, st});
    par(0, IDX_STATUS, 0); check(rdat[7:5], 3'h3);
    att = 1; wt(5); check({o_flt, o_mten}, 2'b00);
    att = 0;
    v = $random(seed);
    home(v);
    boot(3);
    par(0, IDX_FB_REF, 0); check(rdat, v);
    end_of_test;
  end
endmodule : test_absolute_position_tracker
